/* logic/lsm_pkg.sv */
// Constants, register map and reset values of the genset load step manager
package lsm_pkg;

  // Clock and time base
  localparam int CLK_FREQ_HZ  = 100_000_000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES  = CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;
  localparam int PULSE_TIME_MS = 250;
  localparam int PULSE_TICKS  = PULSE_TIME_MS * 1000 / TICK_TIME_US;

  // Structure
  localparam int NUM_STEPS = 5;
  localparam int NUM_GPO   = 8;
  localparam int ROUTE_W   = 3;

  // Configuration word indices (byte address = 4 * index)
  localparam logic [3:0] IDX_SHED_LOW      = 4'h0;
  localparam logic [3:0] IDX_SHED_HIGH     = 4'h1;
  localparam logic [3:0] IDX_STEP_ADD_LVL  = 4'h2;
  localparam logic [3:0] IDX_STEP_REM_LVL  = 4'h3;
  localparam logic [3:0] IDX_SAME_GAP      = 4'h4;
  localparam logic [3:0] IDX_CROSS_GAP     = 4'h5;
  localparam logic [3:0] IDX_CONNECT_START = 4'h6;
  localparam logic [3:0] IDX_REMOVE_START  = 4'h7;
  localparam logic [3:0] IDX_CONNECT_WAIT  = 4'h8;
  localparam logic [3:0] IDX_REMOVE_WAIT   = 4'h9;
  localparam int         NUM_CFG           = 10;

  // Byte offsets of the other registers
  localparam logic [7:0] OFS_OUT_ROUTE = 8'h28;
  localparam logic [7:0] OFS_STATUS    = 8'h2C;
  localparam logic [7:0] OFS_POWER     = 8'h30;

  // Status field positions
  localparam int ST_SHED  = 0;
  localparam int ST_RAISE = 1;
  localparam int ST_LOWER = 2;
  localparam int ST_COUNT = 4;

  // Reset values
  localparam logic [15:0] CFG_RESET [0:NUM_CFG-1] = '{
    16'h0064, 16'h00C8, 16'h0064, 16'h00C8, 16'h03E8,
    16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8};
  localparam logic [23:0] ROUTE_RESET = 24'h000000;

  // Route codes of a general output
  localparam logic [2:0] RT_OFF   = 3'h0;
  localparam logic [2:0] RT_SHED  = 3'h1;
  localparam logic [2:0] RT_DUMMY = 3'h2;
  localparam logic [2:0] RT_RAISE = 3'h3;
  localparam logic [2:0] RT_LOWER = 3'h4;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } lsm_bus_t;

endpackage

/* logic/lsm_top.sv */
// Load shedding, raise/lower requests and five-step load manager with Avalon-MM slave
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module lsm_top import lsm_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic [15:0] POWER_IN,
  input  wire logic [7:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  output logic             SHED_OUT,
  output logic             DUMMY_LOAD_OUT,
  output logic             RAISE_REQ_OUT,
  output logic             LOWER_REQ_OUT,
  output logic      [4:0]  STEP_ADD_OUT,
  output logic      [4:0]  STEP_REMOVE_OUT,
  output logic      [7:0]  GPO_OUT
);

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // What a general output shows for a given route code
  function automatic logic route_val(input logic [2:0] code, input logic shed,
                                     input logic raise, input logic lower);
    logic v;
    case (code)
      RT_SHED:  v = shed;
      RT_DUMMY: v = ~shed;
      RT_RAISE: v = raise;
      RT_LOWER: v = lower;
      default:  v = 1'b0;
    endcase
    return v;
  endfunction

  lsm_bus_t    bus_state;
  lsm_bus_t    next_bus_state;
  logic [15:0] cfg      [0:NUM_CFG-1];
  logic [15:0] next_cfg [0:NUM_CFG-1];
  logic [23:0] route;
  logic [23:0] next_route;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        req;
  logic        wr_take;
  logic [3:0]  idx;

  logic [16:0] pre;
  logic [16:0] next_pre;
  logic        tick;
  logic        shed;
  logic        next_shed;
  logic        raise;
  logic        next_raise;
  logic        lower;
  logic        next_lower;
  logic [15:0] since_raise;
  logic [15:0] next_since_raise;
  logic [15:0] since_lower;
  logic [15:0] next_since_lower;
  logic [2:0]  count;
  logic [2:0]  next_count;
  logic [15:0] add_timer;
  logic [15:0] next_add_timer;
  logic [15:0] rem_timer;
  logic [15:0] next_rem_timer;
  logic [15:0] since_add;
  logic [15:0] next_since_add;
  logic [15:0] since_rem;
  logic [15:0] next_since_rem;
  logic [4:0]  add_pulse;
  logic [4:0]  next_add_pulse;
  logic [4:0]  rem_pulse;
  logic [4:0]  next_rem_pulse;
  logic [8:0]  add_len;
  logic [8:0]  next_add_len;
  logic [8:0]  rem_len;
  logic [8:0]  next_rem_len;
  logic [7:0]  gpo;
  logic [7:0]  next_gpo;
  logic        fire_add;
  logic        fire_rem;

  // Bus handshake: one wait cycle, read data latched before waitrequest drops
  assign req                 = AVS_READ_IN | AVS_WRITE_IN;
  assign AVS_WAITREQUEST_OUT = req & (bus_state != BUS_DONE);
  assign wr_take             = AVS_WRITE_IN & (bus_state == BUS_DONE);
  assign idx                 = AVS_ADDRESS_IN[5:2];
  assign AVS_READDATA_OUT    = rdata;

  // Next bus state, register writes and read decode; unmapped reads give zero
  always_comb begin
    next_bus_state = bus_state;
    next_rdata     = rdata;
    next_route     = route;
    next_cfg       = cfg;
    case (bus_state)
      BUS_IDLE: begin
        if (req) begin
          next_bus_state = BUS_DONE;
          next_rdata     = 32'h00000000;
          if (AVS_ADDRESS_IN[7:6] == 2'h0 && AVS_ADDRESS_IN[1:0] == 2'h0 &&
              idx < NUM_CFG[3:0]) begin
            next_rdata = {16'h0000, cfg[idx]};
          end else if (AVS_ADDRESS_IN == OFS_OUT_ROUTE) begin
            next_rdata = {8'h00, route};
          end else if (AVS_ADDRESS_IN == OFS_STATUS) begin
            next_rdata[ST_SHED]              = shed;
            next_rdata[ST_RAISE]             = raise;
            next_rdata[ST_LOWER]             = lower;
            next_rdata[ST_COUNT +: 3]        = count;
          end else if (AVS_ADDRESS_IN == OFS_POWER) begin
            next_rdata = {16'h0000, POWER_IN};
          end
        end
      end
      BUS_DONE: begin
        next_bus_state = BUS_IDLE;
        if (wr_take) begin
          if (AVS_ADDRESS_IN[7:6] == 2'h0 && AVS_ADDRESS_IN[1:0] == 2'h0 &&
              idx < NUM_CFG[3:0]) begin
            next_cfg[idx] = 16'(be_merge({16'h0000, cfg[idx]}, AVS_WRITEDATA_IN,
                                         AVS_BYTEENABLE_IN));
          end else if (AVS_ADDRESS_IN == OFS_OUT_ROUTE) begin
            next_route = 24'(be_merge({8'h00, route}, AVS_WRITEDATA_IN,
                                      AVS_BYTEENABLE_IN));
          end
        end
      end
      default: next_bus_state = BUS_IDLE;
    endcase
  end

  // Bus and configuration registers
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      bus_state <= BUS_IDLE;
      rdata     <= 32'h00000000;
      route     <= ROUTE_RESET;
      cfg       <= CFG_RESET;
    end else begin
      bus_state <= next_bus_state;
      rdata     <= next_rdata;
      route     <= next_route;
      cfg       <= next_cfg;
    end
  end

  // Millisecond time base shared by every delay
  assign tick = (pre == 17'(TICK_LEN - 1));

  // Start conditions of a step change; removal wins if levels overlap
  assign fire_rem = (POWER_IN > cfg[IDX_STEP_REM_LVL]) && (count != 3'h0) &&
                    (rem_timer >= cfg[IDX_REMOVE_START]) &&
                    (since_rem >= cfg[IDX_REMOVE_WAIT]);
  assign fire_add = !fire_rem && (POWER_IN < cfg[IDX_STEP_ADD_LVL]) &&
                    (count < 3'(NUM_STEPS)) &&
                    (add_timer >= cfg[IDX_CONNECT_START]) &&
                    (since_add >= cfg[IDX_CONNECT_WAIT]);

  // Next values of the control logic
  always_comb begin
    next_pre         = tick ? 17'h00000 : 17'(pre + 17'h00001);
    next_shed        = shed;
    next_raise       = raise;
    next_lower       = lower;
    next_since_raise = since_raise;
    next_since_lower = since_lower;
    next_count       = count;
    next_add_timer   = add_timer;
    next_rem_timer   = rem_timer;
    next_since_add   = since_add;
    next_since_rem   = since_rem;
    next_add_pulse   = add_pulse;
    next_rem_pulse   = rem_pulse;
    next_add_len     = add_len;
    next_rem_len     = rem_len;
    // Hysteresis comparator, free running
    if (POWER_IN > cfg[IDX_SHED_HIGH]) begin
      next_shed = 1'b1;
    end else if (POWER_IN < cfg[IDX_SHED_LOW]) begin
      next_shed = 1'b0;
    end
    // Raise request; re-checked every cycle so a late grant needs power still low
    if (raise) begin
      if (POWER_IN > cfg[IDX_SHED_LOW]) begin
        next_raise = 1'b0;
      end
    end else if (!lower && POWER_IN < cfg[IDX_SHED_LOW] &&
                 since_raise >= cfg[IDX_SAME_GAP] &&
                 since_lower >= cfg[IDX_CROSS_GAP]) begin
      next_raise = 1'b1;
    end
    // Lower request, mirror of the raise path
    if (lower) begin
      if (POWER_IN < cfg[IDX_SHED_HIGH]) begin
        next_lower = 1'b0;
      end
    end else if (!raise && POWER_IN > cfg[IDX_SHED_HIGH] &&
                 since_lower >= cfg[IDX_SAME_GAP] &&
                 since_raise >= cfg[IDX_CROSS_GAP]) begin
      next_lower = 1'b1;
    end
    // Gap counters saturate so a long idle never wraps into a block
    if (next_raise && !raise) begin
      next_since_raise = 16'h0000;
    end else if (tick && since_raise != 16'hFFFF) begin
      next_since_raise = 16'(since_raise + 16'h0001);
    end
    if (next_lower && !lower) begin
      next_since_lower = 16'h0000;
    end else if (tick && since_lower != 16'hFFFF) begin
      next_since_lower = 16'(since_lower + 16'h0001);
    end
    // Start timers restart when the level condition lapses
    if (!(POWER_IN < cfg[IDX_STEP_ADD_LVL]) || fire_add) begin
      next_add_timer = 16'h0000;
    end else if (tick && add_timer != 16'hFFFF) begin
      next_add_timer = 16'(add_timer + 16'h0001);
    end
    if (!(POWER_IN > cfg[IDX_STEP_REM_LVL]) || fire_rem) begin
      next_rem_timer = 16'h0000;
    end else if (tick && rem_timer != 16'hFFFF) begin
      next_rem_timer = 16'(rem_timer + 16'h0001);
    end
    if (tick && since_add != 16'hFFFF) begin
      next_since_add = 16'(since_add + 16'h0001);
    end
    if (tick && since_rem != 16'hFFFF) begin
      next_since_rem = 16'(since_rem + 16'h0001);
    end
    // Pulse length timers
    if (add_pulse != 5'h00 && tick) begin
      next_add_len = 9'(add_len + 9'h001);
      if (next_add_len >= 9'(PULSE_TICKS)) begin
        next_add_pulse = 5'h00;
      end
    end
    if (rem_pulse != 5'h00 && tick) begin
      next_rem_len = 9'(rem_len + 9'h001);
      if (next_rem_len >= 9'(PULSE_TICKS)) begin
        next_rem_pulse = 5'h00;
      end
    end
    // One step at a time: add the next step up, remove the top one
    if (fire_add) begin
      next_count     = 3'(count + 3'h1);
      next_since_add = 16'h0000;
      next_add_pulse = 5'(5'h01 << count);
      next_add_len   = 9'h000;
    end else if (fire_rem) begin
      next_count     = 3'(count - 3'h1);
      next_since_rem = 16'h0000;
      next_rem_pulse = 5'(5'h01 << (count - 3'h1));
      next_rem_len   = 9'h000;
    end
  end

  // Output routing per general output
  genvar g;
  generate
    for (g = 0; g < NUM_GPO; g++) begin : gen_gpo
      assign next_gpo[g] = route_val(route[g*ROUTE_W +: ROUTE_W], next_shed,
                                     next_raise, next_lower);
    end
  endgenerate

  // Control registers; gap counters start saturated so the first request is free
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pre         <= 17'h00000;
      shed        <= 1'b0;
      raise       <= 1'b0;
      lower       <= 1'b0;
      since_raise <= 16'hFFFF;
      since_lower <= 16'hFFFF;
      count       <= 3'h0;
      add_timer   <= 16'h0000;
      rem_timer   <= 16'h0000;
      since_add   <= 16'hFFFF;
      since_rem   <= 16'hFFFF;
      add_pulse   <= 5'h00;
      rem_pulse   <= 5'h00;
      add_len     <= 9'h000;
      rem_len     <= 9'h000;
      gpo         <= 8'h00;
    end else begin
      pre         <= next_pre;
      shed        <= next_shed;
      raise       <= next_raise;
      lower       <= next_lower;
      since_raise <= next_since_raise;
      since_lower <= next_since_lower;
      count       <= next_count;
      add_timer   <= next_add_timer;
      rem_timer   <= next_rem_timer;
      since_add   <= next_since_add;
      since_rem   <= next_since_rem;
      add_pulse   <= next_add_pulse;
      rem_pulse   <= next_rem_pulse;
      add_len     <= next_add_len;
      rem_len     <= next_rem_len;
      gpo         <= next_gpo;
    end
  end

  // Output drive
  assign SHED_OUT        = shed;
  assign DUMMY_LOAD_OUT  = ~shed;
  assign RAISE_REQ_OUT   = raise;
  assign LOWER_REQ_OUT   = lower;
  assign STEP_ADD_OUT    = add_pulse;
  assign STEP_REMOVE_OUT = rem_pulse;
  assign GPO_OUT         = gpo;

  // Checks on the control behaviour
  AST_SHED_SET: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    POWER_IN > cfg[IDX_SHED_HIGH] |=> SHED_OUT) else $error("shed not set");
  AST_SHED_CLR: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    POWER_IN < cfg[IDX_SHED_LOW] && cfg[IDX_SHED_LOW] <= cfg[IDX_SHED_HIGH] |=> !SHED_OUT)
    else $error("shed not cleared");
  AST_SHED_HOLD: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    $changed(SHED_OUT) |-> $past(POWER_IN) > $past(cfg[IDX_SHED_HIGH]) ||
    $past(POWER_IN) < $past(cfg[IDX_SHED_LOW])) else $error("shed moved in band");
  AST_DUMMY: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    DUMMY_LOAD_OUT != SHED_OUT) else $error("dummy not inverse");
  AST_RAISE_GAP: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    $rose(RAISE_REQ_OUT) |-> $past(since_raise) >= $past(cfg[IDX_SAME_GAP]) &&
    $past(since_lower) >= $past(cfg[IDX_CROSS_GAP]) && $past(POWER_IN) <
    $past(cfg[IDX_SHED_LOW])) else $error("raise too early");
  AST_LOWER_GAP: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    $rose(LOWER_REQ_OUT) |-> $past(since_raise) >= $past(cfg[IDX_CROSS_GAP]) &&
    $past(since_lower) >= $past(cfg[IDX_SAME_GAP])) else $error("lower too early");
  AST_RAISE_REL: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    RAISE_REQ_OUT && POWER_IN > cfg[IDX_SHED_LOW] |=> !RAISE_REQ_OUT)
    else $error("raise not released");
  AST_ONE_STEP: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    count != $past(count) |-> (count == 3'($past(count) + 3'h1) &&
    STEP_ADD_OUT == 5'(5'h01 << $past(count))) || (count == 3'($past(count) - 3'h1) &&
    STEP_REMOVE_OUT == 5'(5'h01 << count))) else $error("bad step change");
  AST_MAX_STEP: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    count <= 3'(NUM_STEPS)) else $error("step count overflow");
  AST_PULSE_LEN: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    $fell(|STEP_ADD_OUT) |-> $past(add_len) == 9'(PULSE_TICKS - 1))
    else $error("add pulse wrong length");
  AST_ADD_WAIT: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    count > $past(count) |-> $past(since_add) >= $past(cfg[IDX_CONNECT_WAIT]) &&
    $past(add_timer) >= $past(cfg[IDX_CONNECT_START])) else $error("add too early");
  AST_REM_WAIT: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    count < $past(count) |-> $past(since_rem) >= $past(cfg[IDX_REMOVE_WAIT]) &&
    $past(rem_timer) >= $past(cfg[IDX_REMOVE_START])) else $error("remove too early");
  AST_TIMER_RST: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    !(POWER_IN < cfg[IDX_STEP_ADD_LVL]) |=> add_timer == 16'h0000)
    else $error("add timer kept");

endmodule

/* testbench/lsm_load_model.sv */
// Far-side model: load bank driven by the raise/lower requests and the step relays
`timescale 1ns/10ps
module lsm_load_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] base_in,
  input  wire logic        follow_in,
  input  wire logic        raise_in,
  input  wire logic        lower_in,
  input  wire logic [4:0]  add_in,
  input  wire logic [4:0]  remove_in,
  output logic      [15:0] power_out,
  output logic      [4:0]  conn_out
);
  logic [15:0] ofs;
  logic [4:0]  add_d;
  logic [4:0]  rem_d;

  // Ramp one unit per cycle while a request is held, relays latch on pulse edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ofs      <= 16'h0000;
      add_d    <= 5'h00;
      rem_d    <= 5'h00;
      conn_out <= 5'h00;
    end else begin
      add_d    <= add_in;
      rem_d    <= remove_in;
      conn_out <= (conn_out | (add_in & ~add_d)) & ~(remove_in & ~rem_d);
      if (!follow_in) begin
        ofs <= 16'h0000; // Open loop: the bench sets the power alone
      end else if (raise_in) begin
        ofs <= ofs + 16'h0001;
      end else if (lower_in) begin
        ofs <= ofs - 16'h0001;
      end
    end
  end

  // Genset power seen by the controller
  assign power_out = base_in + ofs;
endmodule

/* testbench/lsm_top_bench.sv */
// Self-checking bench of the load step manager with its load-bank partner
`timescale 1ns/10ps
module lsm_top_bench import lsm_pkg::*;;
  typedef struct packed {logic [15:0] p; logic s; logic r; logic l;} lsm_row_t;
  localparam int TL = 10; // Short ms tick keeps the run brief
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] base = 16'h0096;
  logic        follow = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] q;
  logic        waitreq;
  logic        shed;
  logic        dummy;
  logic        raise;
  logic        lower;
  logic [4:0]  sadd;
  logic [4:0]  srem;
  logic [4:0]  conn;
  logic [7:0]  gpo;
  logic [15:0] power;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // Power, expected shed, raise, lower
  lsm_row_t    rows [0:9] = '{{16'h0096, 3'b000}, {16'h00C9, 3'b101}, {16'h00C8, 3'b101},
    {16'h0096, 3'b100}, {16'h0064, 3'b100}, {16'h0063, 3'b010}, {16'h0096, 3'b000},
    {16'h00C8, 3'b000}, {16'h00FA, 3'b101}, {16'h0000, 3'b010}};

  lsm_top #(.TICK_LEN(TL)) uut (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .POWER_IN(power),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
    .SHED_OUT(shed), .DUMMY_LOAD_OUT(dummy), .RAISE_REQ_OUT(raise), .LOWER_REQ_OUT(lower),
    .STEP_ADD_OUT(sadd), .STEP_REMOVE_OUT(srem), .GPO_OUT(gpo));

  lsm_load_model load (.clk_in(clk), .rst_n_in(rst_n), .base_in(base), .follow_in(follow),
    .raise_in(raise), .lower_in(lower), .add_in(sadd), .remove_in(srem),
    .power_out(power), .conn_out(conn));

  // Clock
  always #5 clk = ~clk;

  // Hang guard, well above the roughly 30000 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; waitrequest and read data are taken at the same rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= ~w;
    @(posedge clk);
    while (waitreq !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n < 50}, 32'h1);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic cfg(input logic [3:0] i, input logic [15:0] v);
    bus(1'b1, {2'b00, i, 2'b00}, {16'h0000, v});
  endtask

  // Set power, let n edges pass, end settled at a falling edge
  task automatic setp(input logic [15:0] v, input int n);
    @(posedge clk);
    base <= v;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Wait lo..hi cycles for one step pulse on bit idx, then time its length
  task automatic pulse(input logic rem, input int idx, input int lo, input int hi);
    int n;
    int m;
    n = 0;
    m = 0;
    while ((rem ? srem : sadd) === 5'h00 && n < hi) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, n >= lo && n < hi}, 32'h1);
    chk(rem ? srem : sadd, 5'h01 << idx);
    while ((rem ? srem[idx] : sadd[idx]) === 1'b1 && m < 3000) begin
      @(negedge clk);
      m++;
    end
    chk({31'h0, m >= (PULSE_TICKS - 1) * TL && m <= PULSE_TICKS * TL}, 32'h1);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b1, OFS_OUT_ROUTE, {8'h00, RT_OFF, RT_OFF, 3'h5, RT_OFF, RT_LOWER, RT_RAISE,
      RT_DUMMY, RT_SHED});
    cfg(IDX_SAME_GAP, 16'h0000);
    cfg(IDX_CROSS_GAP, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      setp(rows[i].p, 3);
      chk({shed, dummy, raise, lower}, {rows[i].s, ~rows[i].s, rows[i].r, rows[i].l});
      chk(gpo, {4'h0, rows[i].l, rows[i].r, ~rows[i].s, rows[i].s});
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(q, {29'h0, rows[i].l, rows[i].r, rows[i].s});
    end
    // Gap timing with 5 ms gaps; the ms tick phase adds up to 10 cycles
    cfg(IDX_SAME_GAP, 16'h0005);
    cfg(IDX_CROSS_GAP, 16'h0005);
    setp(16'h0096, 80);
    setp(16'h00FA, 2);
    chk(lower, 1'b1);
    setp(16'h0032, 20);
    chk({raise, lower}, 2'b00);
    setp(16'h0096, 40);
    chk(raise, 1'b0);
    setp(16'h0032, 2);
    chk(raise, 1'b1);
    setp(16'h0096, 2);
    chk(raise, 1'b0);
    setp(16'h0032, 25);
    chk(raise, 1'b0);
    setp(16'h0032, 30);
    chk(raise, 1'b1);
    setp(16'h00FA, 2);
    chk(lower, 1'b0);
    setp(16'h00FA, 40);
    chk(lower, 1'b1);
    // Closed loop: the load bank ramps until power passes the low limit
    setp(16'h0096, 80);
    @(posedge clk);
    follow <= 1'b1;
    setp(16'h0032, 80);
    chk(raise, 1'b0);
    chk({31'h0, power > 16'h0064 && power < 16'h0068}, 32'h1);
    @(posedge clk);
    follow <= 1'b0;
    // Five steps connected one by one, then a sixth refused
    cfg(IDX_CONNECT_START, 16'h0005);
    cfg(IDX_CONNECT_WAIT, 16'h012C);
    cfg(IDX_REMOVE_START, 16'h0005);
    cfg(IDX_REMOVE_WAIT, 16'h012C);
    setp(16'h0096, 1); // Hold the add timer at zero so the start delay begins here
    setp(16'h0032, 0);
    pulse(1'b0, 0, 35, 70);
    for (int i = 1; i < 5; i++) pulse(1'b0, i, 450, 560);
    setp(16'h0032, 1000);
    chk(sadd, 5'h00);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q[6:4], 3'h5);
    chk(conn, 5'h1F);
    // Removal from the top down, then a restarted start timer
    setp(16'h00FA, 0);
    pulse(1'b1, 4, 35, 70);
    pulse(1'b1, 3, 450, 560);
    setp(16'h0096, 3200);
    setp(16'h00FA, 30);
    chk(srem, 5'h00);
    setp(16'h0096, 1);
    setp(16'h00FA, 30);
    chk(srem, 5'h00);
    pulse(1'b1, 2, 5, 30);
    chk(conn, 5'h03);
    // Reset in mid-run, then reset values, read-only and unmapped places
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk({shed, dummy, raise, lower, sadd, srem, gpo}, {4'b0100, 18'h00000});
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < NUM_CFG; i++) begin
      bus(1'b0, {i[5:0], 2'b00}, 32'h0);
      chk(q, {16'h0000, CFG_RESET[i]});
    end
    bus(1'b0, OFS_OUT_ROUTE, 32'h0);
    chk(q, {8'h00, ROUTE_RESET});
    bus(1'b0, OFS_POWER, 32'h0);
    chk(q, 32'h0000_00FA);
    bus(1'b1, OFS_STATUS, 32'h0000_007F);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h0000_0005);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0000_0000);
    give_verdict();
  end
endmodule
